// File: verilog/supply_monitor_pkg.sv
// constants, field layouts and carriers of the supply monitor register bank
package supply_monitor_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register indices; the byte address on the bus is four times the index
  localparam logic [5:0] IDX_THRESHOLD = 6'h01;
  localparam logic [5:0] IDX_MARGIN_CTRL = 6'h08;
  localparam logic [5:0] IDX_IRQ_CTRL = 6'h09;
  localparam logic [5:0] IDX_IRQ_FLAGS = 6'h0A;
  localparam logic [5:0] IDX_STATUS = 6'h0B;

  // field positions
  localparam int THRESHOLD_LSB = 0;
  localparam int MARGIN_LSB = 0;
  localparam int IRQ_EN_BIT = 0;
  localparam int EDGE_CFG_LSB = 1;
  localparam int IRQ_FLAG_BIT = 0;
  localparam int BELOW_BIT = 0;

  // reset values
  localparam logic [2:0] THRESHOLD_RST = 3'h0;
  localparam logic [1:0] MARGIN_RST = 2'h0;
  localparam logic [1:0] EDGE_CFG_RST = 2'h0;
  localparam logic IRQ_EN_RST = 1'b0;
  localparam logic IRQ_FLAG_RST = 1'b0;

  // threshold codes, lowest 1.8V to highest 4.30V
  localparam logic [2:0] brownout_threshold_code_lowest = 3'h0;
  localparam logic [2:0] brownout_threshold_code_highest = 3'h7;

  // margin codes above the brown-out level
  localparam logic [1:0] MARGIN_5PCT = 2'h0;
  localparam logic [1:0] MARGIN_15PCT = 2'h1;
  localparam logic [1:0] MARGIN_25PCT = 2'h2;

  // crossing selection codes
  localparam logic [1:0] EDGE_FALLING = 2'h0;
  localparam logic [1:0] EDGE_RISING = 2'h1;
  localparam logic [1:0] EDGE_EITHER = 2'h2;

  // settings handed to the analog comparators
  typedef struct packed {
    logic [2:0] brownout_threshold_sel;
    logic [1:0] monitor_margin_sel;
  } analog_cfg_t;

  // interrupt control register content
  typedef struct packed {
    logic [1:0] monitor_edge_cfg;
    logic monitor_irq_en;
  } irq_ctrl_t;

endpackage

// File: verilog/supply_monitor_regs.sv
// register bank and interrupt logic of the supply brown-out level monitor
//
// Function
// (R01) The threshold selector is three bits, codes 0x0 to 0x7 for levels 1.8V up to 4.30V.
// (R02) The threshold selector is loaded from the fuse field at reset, not from a constant; the code resets it to 0x0 and loads the fuse after release.
// (R03) A two-bit margin sets the monitor level 5%, 15% or 25% above the brown-out level.
// (R04) A two-bit crossing choice selects falling, rising or either crossing as the trigger.
// (R05) Bit 0 of the interrupt control register enables the monitor interrupt.
// (R06) Bit 0 of the flag register is set on every crossing that matches the choice; the code sets it only while the interrupt enable bit is set.
// (R07) The flag changes only while the brown-out detector is enabled.
// (R08) A read-only status bit reads 1 below the monitor level and 0 above it.
// (R09) Software ignores the status bit while the detector is disabled.
// (R10) The monitor stays inactive while the detector is off, whatever the enable bit.
// (R11) An interrupt request stands while enable and flag are both set, until the flag clears.
// (R12) Writing one to the flag bit clears it; writing zero leaves it.
`timescale 1ns/1ps

module supply_monitor_regs
  import supply_monitor_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [supply_monitor_pkg::ADDR_W-1:0] paddr,
  input wire logic [supply_monitor_pkg::DATA_W-1:0] pwdata,
  output logic [supply_monitor_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] brownout_config_fuse,
  input wire logic brownout_detector_en,
  input wire logic monitor_below_raw,
  output supply_monitor_pkg::analog_cfg_t analog_cfg,
  output logic monitor_irq
);

  logic [2:0] threshold_r;
  logic fuse_loaded_r;
  logic [1:0] margin_r;
  irq_ctrl_t irq_ctrl_r;
  logic flag_r;
  logic irq_r;
  logic [DATA_W-1:0] prdata_r;
  logic slverr_r;
  logic [1:0] async_lvl;
  logic [1:0] sync_s2;
  logic [1:0] sync_s3;
  logic below_s2_r;
  logic below_s3_r;
  logic below_r;
  logic det_s2_r;
  logic det_s3_r;
  logic det_r;
  logic below_change;
  logic crossing_hit;
  logic monitor_active;
  logic setup_phase;
  logic access_wr;
  logic flag_clear;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
    reg_hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == idx);
  endfunction

  function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
    reg_mapped = reg_hit(addr, IDX_THRESHOLD) || reg_hit(addr, IDX_MARGIN_CTRL) ||
                 reg_hit(addr, IDX_IRQ_CTRL) || reg_hit(addr, IDX_IRQ_FLAGS) ||
                 reg_hit(addr, IDX_STATUS);
  endfunction

  assign setup_phase = psel && !penable;
  assign access_wr = psel && penable && pwrite && !slverr_r;
  // zero wait states: read data was latched in the setup cycle
  assign pready = psel && penable;
  assign pslverr = psel && penable && slverr_r;
  assign prdata = prdata_r;

  // the fuse level is not sampled under reset; it is caught on the first edge after release
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      threshold_r <= THRESHOLD_RST;
      fuse_loaded_r <= 1'b0;
    end else if (!fuse_loaded_r) begin
      threshold_r <= brownout_config_fuse; // [R01] [R02]
      fuse_loaded_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      margin_r <= MARGIN_RST;
    end else if (access_wr && reg_hit(paddr, IDX_MARGIN_CTRL)) begin
      margin_r <= pwdata[MARGIN_LSB +: 2]; // [R03]
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_ctrl_r.monitor_edge_cfg <= EDGE_CFG_RST;
      irq_ctrl_r.monitor_irq_en <= IRQ_EN_RST;
    end else if (access_wr && reg_hit(paddr, IDX_IRQ_CTRL)) begin
      irq_ctrl_r.monitor_edge_cfg <= pwdata[EDGE_CFG_LSB +: 2]; // [R04]
      irq_ctrl_r.monitor_irq_en <= pwdata[IRQ_EN_BIT]; // [R05]
    end
  end

  assign analog_cfg.brownout_threshold_sel = threshold_r;
  assign analog_cfg.monitor_margin_sel = margin_r;

  assign async_lvl = {brownout_detector_en, monitor_below_raw};

  // three-stage synchronisers; a change counts once stages two and three agree
  for (genvar g = 0; g < 2; g++) begin : g_sync
    logic s1_r;
    logic s2_r;
    logic s3_r;
    // only stage two reads stage one, so a metastable first stage never fans out
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
      end else begin
        s1_r <= async_lvl[g];
        s2_r <= s1_r;
        s3_r <= s2_r;
      end
    end
    assign sync_s2[g] = s2_r;
    assign sync_s3[g] = s3_r;
  end

  assign below_s2_r = sync_s2[0];
  assign below_s3_r = sync_s3[0];
  assign det_s2_r = sync_s2[1];
  assign det_s3_r = sync_s3[1];

  assign below_change = (below_s2_r == below_s3_r) && (below_s3_r != below_r);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      below_r <= 1'b0;
      det_r <= 1'b0;
    end else begin
      if (below_change) begin
        below_r <= below_s3_r; // [R08]
      end
      if (det_s2_r == det_s3_r) begin
        det_r <= det_s3_r;
      end
    end
  end

  // the monitor runs only with the detector on and its enable set
  assign monitor_active = det_r && irq_ctrl_r.monitor_irq_en; // [R10]

  always_comb begin
    crossing_hit = 1'b0;
    if (below_change && monitor_active) begin
      case (irq_ctrl_r.monitor_edge_cfg)
        EDGE_FALLING: crossing_hit = below_s3_r; // [R04] [R06]
        EDGE_RISING: crossing_hit = !below_s3_r;
        EDGE_EITHER: crossing_hit = 1'b1;
        default: crossing_hit = 1'b0;
      endcase
    end
  end

  assign flag_clear = access_wr && reg_hit(paddr, IDX_IRQ_FLAGS) && pwdata[IRQ_FLAG_BIT];

  // a crossing in the clearing cycle wins, so no event is lost
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flag_r <= IRQ_FLAG_RST;
    end else if (det_r) begin // [R07]
      if (crossing_hit) begin
        flag_r <= 1'b1; // [R06]
      end else if (flag_clear) begin
        flag_r <= 1'b0; // [R12]
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_ctrl_r.monitor_irq_en && flag_r; // [R11]
    end
  end

  assign monitor_irq = irq_r;

  // read data and error are latched in setup; reserved bits read zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata_r <= '0;
      slverr_r <= 1'b0;
    end else if (setup_phase) begin
      slverr_r <= !reg_mapped(paddr);
      prdata_r <= '0;
      if (!pwrite) begin
        if (reg_hit(paddr, IDX_THRESHOLD)) begin
          prdata_r[THRESHOLD_LSB +: 3] <= threshold_r;
        end
        if (reg_hit(paddr, IDX_MARGIN_CTRL)) begin
          prdata_r[MARGIN_LSB +: 2] <= margin_r;
        end
        if (reg_hit(paddr, IDX_IRQ_CTRL)) begin
          prdata_r[EDGE_CFG_LSB +: 2] <= irq_ctrl_r.monitor_edge_cfg;
          prdata_r[IRQ_EN_BIT] <= irq_ctrl_r.monitor_irq_en;
        end
        if (reg_hit(paddr, IDX_IRQ_FLAGS)) begin
          prdata_r[IRQ_FLAG_BIT] <= flag_r;
        end
        if (reg_hit(paddr, IDX_STATUS)) begin
          // only meaningful while the detector is enabled
          prdata_r[BELOW_BIT] <= below_r; // [R08]
        end
      end
    end
  end

endmodule // supply_monitor_regs

// File: test/supply_monitor_props.sv
// property checker bound to the supply monitor register bank
`timescale 1ns/1ps
module supply_monitor_props
  import supply_monitor_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pslverr,
  input wire logic monitor_irq,
  input wire logic brownout_detector_en,
  input wire logic monitor_below_raw,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [2:0] brownout_config_fuse,
  input wire supply_monitor_pkg::analog_cfg_t analog_cfg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  chk_fuse_load: assert property ($rose(resetn) |=>
    analog_cfg.brownout_threshold_sel == brownout_config_fuse) else $error("fuse not loaded");
  chk_thresh_fixed: assert property ($past(resetn, 2) |->
    $stable(analog_cfg.brownout_threshold_sel)) else $error("threshold moved");
  chk_margin_out: assert property (wr && paddr == 8'h20 |=>
    analog_cfg.monitor_margin_sel == $past(pwdata[1:0])) else $error("margin not driven");
  chk_irq_disable: assert property (wr && paddr == 8'h24 && !pwdata[0] |->
    ##2 !monitor_irq) else $error("irq kept after disable");
  // a crossing in flight would legally win over the clear, so the supply must be quiet
  chk_flag_clear: assert property (wr && paddr == 8'h28 && pwdata[0]
    && brownout_detector_en && $past(brownout_detector_en, 4)
    && monitor_below_raw == $past(monitor_below_raw, 5) |-> ##2 !monitor_irq)
    else $error("clear ignored");
  // five cycles back covers the synchroniser and the last flag update it still allows
  chk_frozen_off: assert property (!brownout_detector_en
    && !$past(brownout_detector_en, 5) && !monitor_irq && !psel && !$past(psel)
    |=> !monitor_irq) else $error("flag set while off");
  chk_irq_hold: assert property (monitor_irq && !psel && !$past(psel) |=>
    monitor_irq) else $error("irq dropped");
  chk_status_bits: assert property (rd && paddr == 8'h2C |->
    prdata[31:1] == 31'h0) else $error("status upper bits set");
  cover property ($rose(monitor_irq));
  cover property (pslverr);
  cover property (wr && paddr == 8'h28);
endmodule // supply_monitor_props

bind supply_monitor_regs supply_monitor_props chk_u (.clk_sys, .resetn, .psel, .penable,
  .pwrite, .pslverr, .monitor_irq, .brownout_detector_en, .monitor_below_raw, .paddr,
  .pwdata, .prdata, .brownout_config_fuse, .analog_cfg);

// File: test/supply_comparator_model.sv
// behavioural model of the analog supply comparators
`timescale 1ns/1ps
module supply_comparator_model
  import supply_monitor_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [12:0] supply_mv,
  input wire supply_monitor_pkg::analog_cfg_t analog_cfg,
  output logic monitor_below_raw
);
  int trip_mv [8] = '{1800, 2150, 2600, 2950, 3300, 3700, 4000, 4300};
  int pct [4] = '{5, 15, 25, 0};
  // reserved margin code gets an arbitrary 0 percent; real silicon is undefined there
  always @(posedge clk_sys) begin
    monitor_below_raw <= supply_mv * 100 < trip_mv[analog_cfg.brownout_threshold_sel]
      * (100 + pct[analog_cfg.monitor_margin_sel]);
  end
endmodule // supply_comparator_model

// File: test/supply_monitor_regs_tb.sv
// self-checking testbench of the supply monitor register bank
`timescale 1ns/1ps
module supply_monitor_regs_tb;
  import supply_monitor_pkg::*;
  localparam logic [12:0] HI = 13'h1388, LO = 13'h0BB8, MID = 13'h0FA0;
  logic clk_sys = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic det_en = 1'b0, pready, pslverr, raw, irq, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [12:0] mv = HI;
  analog_cfg_t cfg;
  int miscompares = 0, check_count = 0, cyc = 0;
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  supply_monitor_regs dut_u (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .brownout_config_fuse(3'h5), .brownout_detector_en(det_en),
    .monitor_below_raw(raw), .analog_cfg(cfg), .monitor_irq(irq));
  supply_comparator_model cmp_u (.clk_sys, .supply_mv(mv), .analog_cfg(cfg),
    .monitor_below_raw(raw));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // comparator path is three sync stages plus the flag and irq registers
  task automatic settle();
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic t_regs();
    // software only trusts the status bit with the detector on
    det_en <= 1'b1;
    rdchk(8'h04, 32'h5);
    apb(1'b1, 8'h04, 32'h2);
    rdchk(8'h04, 32'h5);
    for (int i = 8; i < 12; i++) rdchk(8'(i * 4), 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, err}, 32'h1);
    mv <= MID;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 8'h20, m);
      @(posedge clk_sys);
      chk(cfg.monitor_margin_sel, m);
      settle();
      rdchk(8'h2C, (m == 1 || m == 2));
    end
  endtask
  task automatic t_edges();
    det_en <= 1'b1;
    mv <= HI;
    apb(1'b1, 8'h20, 32'h0);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 8'h24, (c << 1) | 1);
      apb(1'b1, 8'h28, 32'h1);
      mv <= LO;
      settle();
      rdchk(8'h28, (c == 0 || c == 2));
      chk(irq, (c == 0 || c == 2));
      apb(1'b1, 8'h28, 32'h0);
      rdchk(8'h28, (c == 0 || c == 2));
      apb(1'b1, 8'h28, 32'h1);
      mv <= HI;
      settle();
      rdchk(8'h28, (c == 1 || c == 2));
    end
    apb(1'b1, 8'h24, 32'h4);
    apb(1'b1, 8'h28, 32'h1);
    mv <= LO;
    settle();
    rdchk(8'h28, 32'h0);
  endtask
  task automatic t_off();
    apb(1'b1, 8'h24, 32'h5);
    det_en <= 1'b0;
    settle();
    mv <= HI;
    settle();
    rdchk(8'h28, 32'h0);
    det_en <= 1'b1;
    settle();
    mv <= LO;
    settle();
    det_en <= 1'b0;
    settle();
    apb(1'b1, 8'h28, 32'h1);
    rdchk(8'h28, 32'h1);
    chk(irq, 32'h1);
    apb(1'b1, 8'h24, 32'h4);
    settle();
    chk(irq, 32'h0);
    apb(1'b1, 8'h24, 32'h5);
    det_en <= 1'b1;
    settle();
    apb(1'b1, 8'h28, 32'h1);
    settle();
    chk(irq, 32'h0);
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    t_regs();
    t_edges();
    t_off();
    end_sim();
  end
endmodule // supply_monitor_regs_tb
